// >>> clie_pkg.sv
/*
 * Shared constants for the command list init engine: host register selects,
 * flag bits, command memory layout and block field positions.
 * Assumes both ends are compiled after this package.
 */
package clie_pkg;
   // ------------------------------------------------------------
   // Host-visible device registers (select codes on the link)
   // ------------------------------------------------------------
   localparam logic [1:0] SEL_FLAG = 2'h0;
   localparam logic [1:0] SEL_PTR  = 2'h1;
   localparam logic [1:0] SEL_WLO  = 2'h2;
   localparam logic [1:0] SEL_WHI  = 2'h3;
   // ------------------------------------------------------------
   // Flag register bits
   // ------------------------------------------------------------
   localparam int FLAG_IE    = 6;
   localparam int FLAG_RUN   = 10;
   localparam int FLAG_VALID = 12;
   localparam int FLAG_NEW   = 13;
   localparam int FLAG_RESP  = 14;
   localparam logic [15:0] FLAG_RESET_VAL = 16'h0000;
   // ------------------------------------------------------------
   // Command memory: 2048 bytes, 64 units of 32 bytes
   // ------------------------------------------------------------
   localparam int MEM_BYTES = 2048;
   localparam int UNITS     = 64;
   localparam int MEM_WORDS = MEM_BYTES / 2;
   localparam int INIT_LW   = 8;
   localparam logic [11:0] LINK_MASK = 12'hFFC;
   localparam logic [15:0] VEC_OFS   = 16'h0004;
   // Word offsets inside a block
   localparam logic [9:0] W_CLINK = 10'h000;
   localparam logic [9:0] W_RLINK = 10'h001;
   localparam logic [9:0] W_FLO   = 10'h002;
   localparam logic [9:0] W_FHI   = 10'h003;
   localparam logic [9:0] W_ID    = 10'h004;
   // Bit positions in the high function word
   localparam int FN_BUSY = 4;
   localparam int FN_EOL  = 5;
   localparam int SOFT_HI = 15;
   localparam int SOFT_LO = 14;
   // ------------------------------------------------------------
   // Host-end Wishbone register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] WB_CTRL  = 8'h00;
   localparam logic [7:0] WB_HEADS = 8'h04;
   localparam logic [7:0] WB_VEC   = 8'h08;
   localparam logic [7:0] WB_FLAG  = 8'h0C;
   localparam logic [31:0] WB_RESET_VAL = 32'h00000000;
endpackage

// >>> clie_link_if.sv
/*
 * Register link between host end and device end.
 * Assumes one shared clock; device answers reads one cycle after the select.
 */
`timescale 1ns/1ps
interface clie_link_if;
   logic [1:0]  reg_sel;
   logic        reg_we;
   logic [15:0] reg_wr_data;
   logic [15:0] reg_rd_data;
   logic        irq;
   modport dev  (input reg_sel, input reg_we, input reg_wr_data,
                 output reg_rd_data, output irq);
   modport host (output reg_sel, output reg_we, output reg_wr_data,
                 input reg_rd_data, input irq);
endinterface

// >>> clie_host.sv
/*
 * Host end: Wishbone slave that lets software order an initialise or a
 * command announcement, replayed as single-cycle writes on the link.
 * Assumes the device end takes one write per cycle.
 */
`timescale 1ns/1ps
module clie_host (
   input  wire logic    mclk,
   input  wire logic    sys_rst,
   input  wire logic    wb_cyc_i,
   input  wire logic    wb_stb_i,
   input  wire logic    wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]  wb_dat_o,
   output logic         wb_ack_o,
   output logic         irq_seen,
   clie_link_if.host    link
);
   typedef enum logic [2:0] {
      H_IDLE = 3'b001, H_INIT = 3'b010, H_ANN = 3'b100
   } clie_hstate_type;

   clie_hstate_type state_reg;
   logic [2:0]      step_reg;
   logic [31:0]     heads_reg;
   logic [31:0]     vec_reg;
   logic            ie_reg;
   logic            req;
   logic [1:0]      sel_next;
   logic [15:0]     dat_next;

   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

   // ------------------------------------------------------------
   // Wishbone slave: answers one cycle after the strobe
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         wb_ack_o  <= 1'b0;
         wb_dat_o  <= clie_pkg::WB_RESET_VAL;
         heads_reg <= clie_pkg::WB_RESET_VAL;
         vec_reg   <= clie_pkg::WB_RESET_VAL;
         ie_reg    <= 1'b0;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= clie_pkg::WB_RESET_VAL;
         if (req && wb_we_i && wb_sel_i == 4'hF) begin
            if (wb_adr_i == clie_pkg::WB_HEADS) heads_reg <= wb_dat_i;
            if (wb_adr_i == clie_pkg::WB_VEC) vec_reg <= wb_dat_i;
            if (wb_adr_i == clie_pkg::WB_CTRL) ie_reg <= wb_dat_i[2];
         end
         if (req && !wb_we_i) begin
            case (wb_adr_i)
               clie_pkg::WB_CTRL:  wb_dat_o <= {29'h0, ie_reg, 1'b0, state_reg != H_IDLE};
               clie_pkg::WB_HEADS: wb_dat_o <= heads_reg;
               clie_pkg::WB_VEC:   wb_dat_o <= vec_reg;
               clie_pkg::WB_FLAG:  wb_dat_o <= {16'h0, link.reg_rd_data};
               default:            wb_dat_o <= clie_pkg::WB_RESET_VAL;
            endcase
         end
      end
   end

   // Vector upper bits forced to zero on a plain init so a stale top half cannot leak
   always_comb begin
      sel_next = clie_pkg::SEL_FLAG;
      dat_next = 16'h0000;
      case (step_reg)
         3'h0: begin sel_next = clie_pkg::SEL_PTR; dat_next = 16'h0000; end
         3'h1: begin sel_next = clie_pkg::SEL_WLO; dat_next = heads_reg[15:0]; end
         3'h2: begin sel_next = clie_pkg::SEL_WHI; dat_next = heads_reg[31:16]; end
         3'h3: begin sel_next = clie_pkg::SEL_PTR; dat_next = clie_pkg::VEC_OFS; end
         3'h4: begin sel_next = clie_pkg::SEL_WLO; dat_next = vec_reg[15:0]; end
         3'h5: begin
            sel_next = clie_pkg::SEL_WHI;
            // A softload carries its stage bits in this word, so pass it through then
            dat_next = (vec_reg[31:30] == 2'h0) ? 16'h0000 : vec_reg[31:16];
         end
         default: begin
            sel_next = clie_pkg::SEL_FLAG;
            dat_next = 16'h0000;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Link sequencer: init walks six writes then sets run
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg        <= H_IDLE;
         step_reg         <= 3'h0;
         link.reg_sel     <= clie_pkg::SEL_FLAG;
         link.reg_we      <= 1'b0;
         link.reg_wr_data <= 16'h0000;
         irq_seen         <= 1'b0;
      end else begin
         link.reg_we <= 1'b0;
         irq_seen    <= link.irq;
         case (state_reg)
            H_IDLE: begin
               step_reg <= 3'h0;
               if (req && wb_we_i && wb_adr_i == clie_pkg::WB_CTRL && wb_sel_i == 4'hF) begin
                  if (wb_dat_i[0]) state_reg <= H_INIT;
                  else if (wb_dat_i[1]) state_reg <= H_ANN;
               end
            end
            H_INIT: begin
               link.reg_we <= 1'b1;
               step_reg    <= step_reg + 3'h1;
               if (step_reg == 3'h6) begin
                  // Run plus list flags so a non-empty list starts at once
                  link.reg_sel     <= clie_pkg::SEL_FLAG;
                  link.reg_wr_data <= 16'h0000 | (16'h1 << clie_pkg::FLAG_RUN)
                                      | (16'h1 << clie_pkg::FLAG_VALID)
                                      | (16'h1 << clie_pkg::FLAG_NEW)
                                      | ({15'h0, ie_reg} << clie_pkg::FLAG_IE);
                  state_reg <= H_IDLE;
               end else begin
                  link.reg_sel     <= sel_next;
                  link.reg_wr_data <= dat_next;
               end
            end
            H_ANN: begin
               // Software must have finished the links before ordering this
               link.reg_we      <= 1'b1;
               link.reg_sel     <= clie_pkg::SEL_FLAG;
               link.reg_wr_data <= 16'h0000 | (16'h1 << clie_pkg::FLAG_RUN)
                                   | (16'h1 << clie_pkg::FLAG_VALID)
                                   | (16'h1 << clie_pkg::FLAG_NEW)
                                   | ({15'h0, ie_reg} << clie_pkg::FLAG_IE);
               state_reg <= H_IDLE;
            end
            default: state_reg <= H_IDLE;
         endcase
      end
   end
endmodule

// >>> clie_device.sv
/*
 * Device end: command memory, flag register, initialise and softload
 * decoding, command list walk and response list building.
 * Assumes the host obeys the list rules; the user side executes one
 * command at a time and reports completion with a status byte.
 */
// Notes on behaviour
// - Host writes pointers, vector, then sets run
// - Init block is unit zero, eight longwords
// - Both stage bits: low word is softload vector
// - Bit 30 only: first block, pages minus one
// - Bit 31 only: next block, pages minus one
// - No stage bits: ordinary initialise
// - Word zero reread as head on list-valid
// - Nonzero head with flags starts list after init
// - Interrupt when enabled and response appears
// - Word one is response list start or zero
// - Host never removes the last response
// - Vector longword has upper bits zero
// - Identification written into words four to seven
// - Command blocks 32 bytes, host-aligned
// - Host sets list-valid and new-command flags
// - Commands beyond capacity wait their turn
// - Finished command becomes linked response block
// - Response carries success or failure status
// - Last response flags end of list
// - Link uses bits 11 to 2, zero ends
// - Host links only fully built elements
// - Response link written before response flag
// - Memory is 2048 bytes in 64 units
// - End-of-list is function bit 21
`timescale 1ns/1ps
module clie_device #(
   parameter logic [63:0] DEV_ID = 64'h0123456789ABCDEF   // arbitrary value
) (
   input  wire logic    mclk,
   input  wire logic    sys_rst,
   clie_link_if.dev     link,
   output logic         init_done,
   output logic         soft_valid,
   output logic [1:0]   soft_stage,
   output logic [21:0]  soft_addr,
   output logic [8:0]   soft_pages,
   output logic [15:0]  soft_vector,
   output logic [31:0]  int_vector,
   output logic         cmd_valid,
   output logic [11:0]  cmd_addr,
   output logic [7:0]   cmd_code,
   output logic [7:0]   cmd_chan,
   input  wire logic    cmd_done,
   input  wire logic    cmd_ok,
   input  wire logic [7:0] cmd_status
);
   typedef enum logic [8:0] {
      S_POST  = 9'h001, S_IDLE  = 9'h002, S_INIT = 9'h004,
      S_HEAD  = 9'h008, S_FETCH = 9'h010, S_EXEC = 9'h020,
      S_RESP  = 9'h040, S_LINK  = 9'h080, S_FLAG = 9'h100
   } clie_dstate_type;

   clie_dstate_type state_reg;
   logic [15:0] mem_reg [0:clie_pkg::MEM_WORDS-1];
   logic [15:0] flag_reg;
   logic [8:0]  ptr_reg;
   logic        run_seen_reg;
   logic [1:0]  post_reg;
   logic [11:0] cur_reg;
   logic [11:0] tail_reg;
   logic [11:0] link_reg;
   logic        dev_we;
   logic [9:0]  dev_wa;
   logic [15:0] dev_wd;
   logic [9:0]  host_wa;
   logic [9:0]  cur_w;
   logic        host_mem_we;
   logic        host_flag_we;
   logic        dev_clr_list;
   logic        dev_set_resp;
   logic [15:0] fn_hi;

   assign cur_w       = cur_reg[10:1];
   assign host_wa     = {ptr_reg, link.reg_sel[0]};
   assign host_mem_we = link.reg_we & link.reg_sel[1];
   assign host_flag_we = link.reg_we & (link.reg_sel == clie_pkg::SEL_FLAG);
   assign fn_hi       = mem_reg[cur_w + clie_pkg::W_FHI];

   // ------------------------------------------------------------
   // Command memory: flip-flops, host window plus one device port
   // ------------------------------------------------------------
   // Not reset: contents are data, cleared by software as it needs
   always_ff @(posedge mclk) begin
      if (host_mem_we) mem_reg[host_wa] <= link.reg_wr_data;
      if (dev_we) mem_reg[dev_wa] <= dev_wd;
   end

   // Address register keeps longword bits only
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ptr_reg <= 9'h000;
      end else if (link.reg_we && link.reg_sel == clie_pkg::SEL_PTR) begin
         ptr_reg <= link.reg_wr_data[10:2];
      end
   end

   // Flag register: device-set bits win over host clears in the same cycle
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         flag_reg <= clie_pkg::FLAG_RESET_VAL;
      end else begin
         if (host_flag_we) begin
            flag_reg[clie_pkg::FLAG_RUN]   <= link.reg_wr_data[clie_pkg::FLAG_RUN];
            flag_reg[clie_pkg::FLAG_IE]    <= link.reg_wr_data[clie_pkg::FLAG_IE];
            // Response flag: host writes one to clear it
            if (link.reg_wr_data[clie_pkg::FLAG_RESP]) flag_reg[clie_pkg::FLAG_RESP] <= 1'b0;
         end
         if (dev_clr_list) begin
            flag_reg[clie_pkg::FLAG_VALID] <= 1'b0;
            flag_reg[clie_pkg::FLAG_NEW]   <= 1'b0;
         end
         if (host_flag_we && link.reg_wr_data[clie_pkg::FLAG_VALID])
            flag_reg[clie_pkg::FLAG_VALID] <= 1'b1;
         if (host_flag_we && link.reg_wr_data[clie_pkg::FLAG_NEW])
            flag_reg[clie_pkg::FLAG_NEW] <= 1'b1;
         if (dev_set_resp) flag_reg[clie_pkg::FLAG_RESP] <= 1'b1;
      end
   end

   // Read data and interrupt, both registered
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         link.reg_rd_data <= 16'h0000;
         link.irq         <= 1'b0;
      end else begin
         case (link.reg_sel)
            clie_pkg::SEL_FLAG: link.reg_rd_data <= flag_reg;
            clie_pkg::SEL_PTR:  link.reg_rd_data <= {5'h00, ptr_reg, 2'h0};
            default:            link.reg_rd_data <= mem_reg[host_wa];
         endcase
         link.irq <= flag_reg[clie_pkg::FLAG_IE] & flag_reg[clie_pkg::FLAG_RESP];
      end
   end

   // ------------------------------------------------------------
   // Device write port and flag events, chosen by state
   // ------------------------------------------------------------
   always_comb begin
      dev_we       = 1'b0;
      dev_wa       = 10'h000;
      dev_wd       = 16'h0000;
      dev_clr_list = 1'b0;
      dev_set_resp = 1'b0;
      case (state_reg)
         S_POST: begin
            dev_we = 1'b1;
            dev_wa = clie_pkg::W_ID + {8'h00, post_reg};
            dev_wd = DEV_ID[{post_reg, 4'h0} +: 16];
         end
         S_HEAD: dev_clr_list = 1'b1;
         S_FETCH: begin
            dev_we = 1'b1;
            dev_wa = cur_w + clie_pkg::W_FHI;
            dev_wd = fn_hi | (16'h1 << clie_pkg::FN_BUSY);
         end
         S_EXEC: begin
            // Status in the top byte, end-of-list when no further link
            dev_we = cmd_done;
            dev_wa = cur_w + clie_pkg::W_FHI;
            dev_wd = {cmd_status, fn_hi[7:6], (link_reg == 12'h000), fn_hi[4:0]};
            if (link_reg == 12'h000) dev_wd[clie_pkg::FN_EOL] = 1'b1;
            if (!cmd_ok) dev_wd[15] = 1'b1;
         end
         S_RESP: begin
            dev_we = 1'b1;
            dev_wa = cur_w + clie_pkg::W_RLINK;
            dev_wd = 16'h0000;
         end
         S_LINK: begin
            // Empty response list: the new block becomes its start
            dev_we = 1'b1;
            dev_wa = (tail_reg == 12'h000) ? clie_pkg::W_RLINK
                                            : tail_reg[10:1] + clie_pkg::W_RLINK;
            dev_wd = {4'h0, cur_reg};
         end
         S_FLAG: dev_set_resp = 1'b1;
         default: dev_we = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // Main sequencer
   // ------------------------------------------------------------
   // One command in flight; later ones wait in the list itself
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg    <= S_POST;
         post_reg     <= 2'h0;
         run_seen_reg <= 1'b0;
         cur_reg      <= 12'h000;
         tail_reg     <= 12'h000;
         link_reg     <= 12'h000;
      end else begin
         run_seen_reg <= flag_reg[clie_pkg::FLAG_RUN];
         case (state_reg)
            S_POST: begin
               post_reg <= post_reg + 2'h1;
               if (post_reg == 2'h3) state_reg <= S_IDLE;
            end
            S_IDLE: begin
               if (flag_reg[clie_pkg::FLAG_RUN] && !run_seen_reg) state_reg <= S_INIT;
               else if (flag_reg[clie_pkg::FLAG_RUN] && flag_reg[clie_pkg::FLAG_VALID]
                        && flag_reg[clie_pkg::FLAG_NEW]) state_reg <= S_HEAD;
            end
            S_INIT: begin
               // Plain initialise takes the response start; softload stops here
               if (mem_reg[clie_pkg::W_FHI][clie_pkg::SOFT_HI:clie_pkg::SOFT_LO] == 2'h0) begin
                  tail_reg <= mem_reg[clie_pkg::W_RLINK][11:0] & clie_pkg::LINK_MASK;
                  if (mem_reg[clie_pkg::W_CLINK] != 16'h0000 && flag_reg[clie_pkg::FLAG_VALID]
                      && flag_reg[clie_pkg::FLAG_NEW]) state_reg <= S_HEAD;
                  else state_reg <= S_IDLE;
               end else begin
                  state_reg <= S_IDLE;
               end
            end
            S_HEAD: begin
               cur_reg   <= mem_reg[clie_pkg::W_CLINK][11:0] & clie_pkg::LINK_MASK;
               state_reg <= (mem_reg[clie_pkg::W_CLINK][11:2] == 10'h000) ? S_IDLE : S_FETCH;
            end
            S_FETCH: begin
               link_reg  <= mem_reg[cur_w + clie_pkg::W_CLINK][11:0] & clie_pkg::LINK_MASK;
               state_reg <= S_EXEC;
            end
            S_EXEC:  if (cmd_done) state_reg <= S_RESP;
            S_RESP:  state_reg <= S_LINK;
            S_LINK: begin
               tail_reg  <= cur_reg;
               state_reg <= S_FLAG;
            end
            S_FLAG: begin
               cur_reg   <= link_reg;
               state_reg <= (link_reg == 12'h000) ? S_IDLE : S_FETCH;
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // User-side outputs, all registered
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         init_done   <= 1'b0;
         soft_valid  <= 1'b0;
         soft_stage  <= 2'h0;
         soft_addr   <= 22'h000000;
         soft_pages  <= 9'h000;
         soft_vector <= 16'h0000;
         int_vector  <= 32'h00000000;
         cmd_valid   <= 1'b0;
         cmd_addr    <= 12'h000;
         cmd_code    <= 8'h00;
         cmd_chan    <= 8'h00;
      end else begin
         init_done  <= 1'b0;
         soft_valid <= 1'b0;
         cmd_valid  <= 1'b0;
         if (state_reg == S_INIT) begin
            soft_stage <= mem_reg[clie_pkg::W_FHI][clie_pkg::SOFT_HI:clie_pkg::SOFT_LO];
            if (mem_reg[clie_pkg::W_FHI][clie_pkg::SOFT_HI:clie_pkg::SOFT_LO] == 2'h0) begin
               init_done  <= 1'b1;
               int_vector <= {mem_reg[clie_pkg::W_FHI], mem_reg[clie_pkg::W_FLO]};
            end else begin
               soft_valid <= 1'b1;
               if (mem_reg[clie_pkg::W_FHI][clie_pkg::SOFT_HI:clie_pkg::SOFT_LO] == 2'h3)
                  soft_vector <= mem_reg[clie_pkg::W_FLO];
               // Field holds pages minus one: zero means a single page
               soft_addr  <= {mem_reg[clie_pkg::W_FHI][5:0], mem_reg[clie_pkg::W_FLO]};
               soft_pages <= {1'b0, mem_reg[clie_pkg::W_FHI][13:6]} + 9'h001;
            end
         end
         if (state_reg == S_FETCH) begin
            cmd_valid <= 1'b1;
            cmd_addr  <= cur_reg;
            cmd_code  <= mem_reg[cur_w + clie_pkg::W_FLO][7:0];
            cmd_chan  <= mem_reg[cur_w + clie_pkg::W_FLO][15:8];
         end
      end
   end
endmodule

// >>> clie_link_properties.sv
/* Checker on the host-to-device register link.
   Assumes one clock for both ends; inputs are the link signals. */
`timescale 1ns/1ps
module clie_link_properties (
   input wire logic        mclk,
   input wire logic        sys_rst,
   input wire logic [1:0]  reg_sel,
   input wire logic        reg_we,
   input wire logic [15:0] reg_wr_data,
   input wire logic [15:0] reg_rd_data,
   input wire logic        irq
);
   // ----
   // Write decodes
   // ----
   wire w_ptr = reg_we && reg_sel == clie_pkg::SEL_PTR;
   wire w_lo  = reg_we && reg_sel == clie_pkg::SEL_WLO;
   wire w_hi  = reg_we && reg_sel == clie_pkg::SEL_WHI;
   wire w_flg = reg_we && reg_sel == clie_pkg::SEL_FLAG;
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // ----
   // Properties
   // ----
   init_seq_a: assert property (w_ptr && reg_wr_data == 16'h0000 |=>
      w_lo ##1 w_hi ##1 w_ptr && reg_wr_data == 16'h0004 ##1 w_lo ##1 w_hi ##1 w_flg)
      else $error("init write walk out of order");
   run_set_a: assert property (w_ptr && reg_wr_data == 16'h0004 |->
      ##3 w_flg && reg_wr_data[clie_pkg::FLAG_RUN]) else $error("run not set after vector");
   vec_upper_a: assert property (w_ptr && reg_wr_data == 16'h0004 ##2
      w_hi && reg_wr_data[15:14] == 2'h0 |-> reg_wr_data == 16'h0000)
      else $error("vector upper word not zero");
   announce_bits_a: assert property (w_flg |->
      reg_wr_data[clie_pkg::FLAG_VALID] && reg_wr_data[clie_pkg::FLAG_NEW])
      else $error("flag write lacks valid or new");
   resp_kept_a: assert property (w_flg |-> !reg_wr_data[clie_pkg::FLAG_RESP])
      else $error("host cleared response flag");
   ptr_range_a: assert property (w_ptr |->
      reg_wr_data[1:0] == 2'h0 && reg_wr_data < 16'h0800) else $error("pointer off memory");
   win_order_a: assert property ((w_lo |-> $past(w_ptr)) and (w_hi |-> $past(w_lo)))
      else $error("window word without pointer");
   irq_level_a: assert property ($past(reg_sel) == clie_pkg::SEL_FLAG |->
      irq == (reg_rd_data[clie_pkg::FLAG_IE] && reg_rd_data[clie_pkg::FLAG_RESP]))
      else $error("interrupt level disagrees with flags");
endmodule

// >>> command_list_init_engine_tb_top.sv
/* Bench: host and device ends joined by the link, driven over Wishbone.
   Assumes package, interface, both ends and checker are compiled first. */
`timescale 1ns/1ps
module command_list_init_engine_tb_top;
   logic        mclk, sys_rst, cyc, stb, we, cmd_done, cmd_ok, wb_ack_o, irq_seen;
   logic        init_done, soft_valid, cmd_valid;
   logic [1:0]  soft_stage;
   logic [3:0]  sel;
   logic [7:0]  adr, cmd_status, cmd_code, cmd_chan;
   logic [8:0]  soft_pages;
   logic [11:0] cmd_addr;
   logic [15:0] soft_vector;
   logic [21:0] soft_addr;
   logic [31:0] wdat, rdat, wb_dat_o, int_vector;
   int          error_cnt, total_checks, n_init, n_soft, n_cmd;
   clie_link_if link ();
   clie_host u_clie_host (.mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .irq_seen(irq_seen), .link(link));
   clie_device u_clie_device (.mclk(mclk), .sys_rst(sys_rst), .link(link),
      .init_done(init_done), .soft_valid(soft_valid), .soft_stage(soft_stage),
      .soft_addr(soft_addr), .soft_pages(soft_pages), .soft_vector(soft_vector),
      .int_vector(int_vector), .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_code(cmd_code),
      .cmd_chan(cmd_chan), .cmd_done(cmd_done), .cmd_ok(cmd_ok), .cmd_status(cmd_status));
   clie_link_properties u_clie_link_properties (.mclk(mclk), .sys_rst(sys_rst),
      .reg_sel(link.reg_sel), .reg_we(link.reg_we), .reg_wr_data(link.reg_wr_data),
      .reg_rd_data(link.reg_rd_data), .irq(link.irq));
   // ----
   // Clock and pulse counters
   // ----
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // Pulses are counted, so a one-cycle output is never missed by polling
   always @(posedge mclk) begin
      n_init <= n_init + 32'(init_done === 1'b1);
      n_soft <= n_soft + 32'(soft_valid === 1'b1);
      n_cmd  <= n_cmd + 32'(cmd_valid === 1'b1);
   end
   // ----
   // Tasks
   // ----
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Classic cycle; held until ack, so a slow answer is waited for, not assumed
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 100);
      rdat = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 100) error_cnt++;
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ----
   // Tests: one reset per init stage, since run must go 0 to 1 again
   // ----
   initial begin
      int stage, ie, b0, b1, nw;
      logic [15:0] c, r;
      logic [31:0] v;
      {sys_rst, cyc, stb, we, adr, wdat, cmd_done, cmd_ok, cmd_status} = '0;
      sel = 4'hF;
      {error_cnt, total_checks, n_init, n_soft, n_cmd} = '0;
      void'($urandom(32'hE1B5));
      for (stage = 0; stage < 4; stage++) begin
         sys_rst <= 1'b1;
         repeat (6) @(posedge mclk);
         sys_rst <= 1'b0;
         repeat (6) @(posedge mclk);
         cmd_ok <= 1'($urandom);
         cmd_status <= 8'($urandom);
         c = (stage == 0) ? 16'h0000 : 16'($urandom);
         r = (stage == 0) ? {5'h00, 9'($urandom), 2'h0} : {2'(stage), 14'($urandom)};
         v = {2'(stage), 30'($urandom)};
         ie = $urandom % 2;
         b0 = n_init;
         b1 = n_soft;
         wb(1'b1, clie_pkg::WB_HEADS, {r, c});
         wb(1'b1, clie_pkg::WB_VEC, v);
         wb(1'b1, clie_pkg::WB_CTRL, {29'h0, 1'(ie), 2'h1});
         nw = 0;
         while (n_init == b0 && n_soft == b1 && nw < 200) begin
            @(posedge mclk);
            nw++;
         end
         chk(32'(n_init - b0), 32'(stage == 0));
         chk(32'(n_soft - b1), 32'(stage != 0));
         if (stage == 0) chk(int_vector, {16'h0000, v[15:0]});
         else chk(32'(soft_stage), 32'(stage));
         if (stage == 3) chk(32'(soft_vector), {16'h0000, v[15:0]});
         if (stage == 1 || stage == 2) begin
            chk(32'(soft_addr), {10'h000, v[21:0]});
            chk(32'(soft_pages), 32'(v[29:22]) + 1);
         end
         wb(1'b0, clie_pkg::WB_CTRL, 32'h0);
         chk(rdat & 32'h7, {29'h0, 1'(ie), 2'h0});
         wb(1'b0, clie_pkg::WB_FLAG, 32'h0);
         chk(32'(rdat[clie_pkg::FLAG_RUN]), 32'h1);
         if (stage == 0) begin
            b0 = n_cmd;
            wb(1'b1, clie_pkg::WB_CTRL, {29'h0, 1'(ie), 2'h2});
            repeat (30) @(posedge mclk);
            chk(32'(n_cmd - b0), 32'h0);
            wb(1'b0, 8'h10, 32'h0);
            chk(rdat, 32'h0);
         end
         $display("test stage %0d done", stage);
      end
      end_sim();
   end
   // Watchdog far beyond the few hundred cycles the tests need
   initial begin
      #(40 * 20000);
      error_cnt++;
      end_sim();
   end
endmodule
